/* rtl/sleep_wake_pkg.sv */
package sleep_wake_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int WDT_PERIOD_US = 1000;
    localparam int WDT_PERIOD_CYCLES = WDT_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int WDT_CNT_W = 24;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int PSC_W = 8;
    localparam int PORT_W = 4;
    localparam int CMP_W = 2;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OPTION_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] WAKE_CTRL_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 3'h4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] OPTION_RESET = 8'hff;
    localparam logic [DATA_W-1:0] WAKE_CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IRQ_RESET = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int OPT_PORT_WAKE_EN_N_BIT = 7;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam int CTRL_CMP_WAKE_EN_BIT = 0;
    localparam int ST_PORT_WAKE_BIT = 7;
    localparam int ST_CMP_WAKE_BIT = 6;
    localparam int ST_ASLEEP_BIT = 5;
    localparam int ST_TIMEOUT_N_BIT = 4;
    localparam int ST_PWRDN_N_BIT = 3;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_WDT_BIT = 1;
    localparam int IRQ_SLEEP_BIT = 2;

    typedef enum logic {PS_RUN, PS_SLEEP} power_state_t;

endpackage

/* rtl/sleep_wake_prescaler.sv */
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sleep_wake_prescaler
#(
    parameter int WDT_CYCLES = sleep_wake_pkg::WDT_PERIOD_CYCLES
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [sleep_wake_pkg::ADDR_W-1:0] ADDR,
    input wire logic [sleep_wake_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [sleep_wake_pkg::DATA_W-1:0] RDATA,
    input wire logic SLEEP_EXEC,
    input wire logic WDT_CLEAR_EXEC,
    input wire logic TIMER_WRITE_EXEC,
    input wire logic PORT_ACCESS_EXEC,
    input wire logic CMP_CONFIG_READ_EXEC,
    input wire logic TIMER_SOURCE_TICK,
    input wire logic WDT_ENABLE,
    input wire logic MASTER_CLEAR_ENABLE,
    input wire logic MASTER_CLEAR_PIN_N,
    input wire logic [sleep_wake_pkg::PORT_W-1:0] PORT_PINS,
    input wire logic [sleep_wake_pkg::CMP_W-1:0] COMPARATOR_OUTPUTS,
    output logic TIMER_INC,
    output logic DEVICE_RESET,
    output logic OSC_DRIVER_EN,
    output logic PIN_HOLD,
    output logic IRQ
);
    import sleep_wake_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    power_state_t pstate_r;
    logic [DATA_W-1:0] option_r;
    logic [DATA_W-1:0] wake_ctrl_r;
    logic [DATA_W-1:0] irq_stat_r;
    logic [DATA_W-1:0] irq_mask_r;
    logic [PSC_W-1:0] psc_r;
    logic [WDT_CNT_W-1:0] wdt_cnt_r;
    logic [PORT_W-1:0] port_snap_r;
    logic [CMP_W-1:0] cmp_snap_r;
    logic timeout_flag_n_r;
    logic powerdown_flag_n_r;
    logic port_wake_flag_r;
    logic comparator_wake_flag_r;
    logic timer_inc_r;
    logic dev_reset_r;
    logic osc_en_r;
    logic pin_hold_r;
    logic irq_r;
    logic [DATA_W-1:0] rdata_r;

    logic prescaler_assign;
    logic [RATIO_W-1:0] prescale_ratio_select;
    logic port_wake_enable_n;
    logic cmp_wake_en;
    logic asleep;
    logic sleep_enter;
    logic wdt_base_tick;
    logic wdt_timeout;
    logic port_mismatch;
    logic cmp_mismatch;
    logic wake_port;
    logic wake_cmp;
    logic wake_master_clear;
    logic wake_any;
    logic awake_reset;
    logic any_reset;
    logic wdt_clear;
    logic psc_clear;
    logic [PSC_W-1:0] tmr_mask;
    logic [PSC_W-1:0] wdt_mask;
    logic [DATA_W-1:0] status_val;
    logic [DATA_W-1:0] irq_events;
    logic [DATA_W-1:0] irq_clear;
    logic [DATA_W-1:0] irq_stat_nxt;

    // Timer ratio 2^(n+1); the ninth bit keeps 1:256 from wrapping.
    function automatic logic [PSC_W-1:0] timer_mask(input logic [RATIO_W-1:0] n);
        logic [PSC_W:0] full;
        full = (9'h002 << n) - 9'h001;
        return full[PSC_W-1:0];
    endfunction

    function automatic logic [PSC_W-1:0] watchdog_mask(input logic [RATIO_W-1:0] n);
        logic [PSC_W:0] full;
        full = (9'h001 << n) - 9'h001;
        return full[PSC_W-1:0];
    endfunction

    // ****************************************************************
    // Decode and event terms
    // ****************************************************************
    assign prescaler_assign = option_r[OPT_ASSIGN_BIT];
    assign prescale_ratio_select = option_r[OPT_RATIO_LSB +: RATIO_W];
    assign port_wake_enable_n = option_r[OPT_PORT_WAKE_EN_N_BIT];
    assign cmp_wake_en = wake_ctrl_r[CTRL_CMP_WAKE_EN_BIT];
    assign asleep = (pstate_r == PS_SLEEP);
    assign sleep_enter = SLEEP_EXEC && !asleep;
    assign tmr_mask = timer_mask(prescale_ratio_select);
    assign wdt_mask = watchdog_mask(prescale_ratio_select);

    assign wdt_base_tick = WDT_ENABLE && (wdt_cnt_r == WDT_CNT_W'(WDT_CYCLES - 1));
    // Without the prescaler the watchdog fires on every base period.
    assign wdt_timeout = wdt_base_tick &&
        (!prescaler_assign || ((psc_r & wdt_mask) == wdt_mask));

    assign port_mismatch = (PORT_PINS != port_snap_r);
    assign cmp_mismatch = (COMPARATOR_OUTPUTS != cmp_snap_r);
    assign wake_port = asleep && !port_wake_enable_n && port_mismatch;
    assign wake_cmp = asleep && cmp_wake_en && cmp_mismatch;
    assign wake_master_clear = MASTER_CLEAR_ENABLE && !MASTER_CLEAR_PIN_N;
    assign wake_any = asleep && (wake_master_clear || wdt_timeout || wake_port || wake_cmp);
    // A watchdog reset while awake pulses the reset and reloads option, but leaves the power state in run.
    assign awake_reset = !asleep && (wake_master_clear || wdt_timeout);
    assign any_reset = wake_any || awake_reset;

    assign wdt_clear = any_reset || sleep_enter || WDT_CLEAR_EXEC || wdt_base_tick;
    assign psc_clear = any_reset ||
        (TIMER_WRITE_EXEC && !prescaler_assign) ||
        (WDT_CLEAR_EXEC && prescaler_assign);

    // ****************************************************************
    // Power state
    // ****************************************************************
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pstate_r <= PS_RUN;
            osc_en_r <= 1'b1;
            pin_hold_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            unique case (pstate_r)
                PS_RUN:
                begin
                    if (sleep_enter && !awake_reset)
                    begin
                        pstate_r <= PS_SLEEP;
                        osc_en_r <= 1'b0;
                        pin_hold_r <= 1'b1;
                    end
                end
                PS_SLEEP:
                begin
                    // Every wake goes through reset back to run.
                    if (wake_any)
                    begin
                        pstate_r <= PS_RUN;
                        osc_en_r <= 1'b1;
                        pin_hold_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    AST_SLEEP_ENTRY: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && sleep_enter && !awake_reset |=> asleep && !OSC_DRIVER_EN && PIN_HOLD)
        else $error("power-down not entered");

    // ****************************************************************
    // Status flags
    // ****************************************************************
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            timeout_flag_n_r <= 1'b1;
            powerdown_flag_n_r <= 1'b1;
        end
        else if (CLK_EN)
        begin
            if (wdt_timeout)
            begin
                timeout_flag_n_r <= 1'b0;
            end
            else if (sleep_enter || WDT_CLEAR_EXEC)
            begin
                timeout_flag_n_r <= 1'b1;
            end
            if (sleep_enter && !awake_reset)
            begin
                powerdown_flag_n_r <= 1'b0;
            end
            else if (WDT_CLEAR_EXEC)
            begin
                powerdown_flag_n_r <= 1'b1;
            end
        end
    end

    AST_SLEEP_FLAGS: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && sleep_enter && !awake_reset && !wdt_timeout
        |=> timeout_flag_n_r && !powerdown_flag_n_r && wdt_cnt_r == '0)
        else $error("sleep entry flags wrong");

    AST_WDT_WAKE_TO: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && asleep && wdt_timeout |=> !timeout_flag_n_r && DEVICE_RESET && !asleep)
        else $error("watchdog wake did not clear timeout flag");

    // Wake cause flags survive the wake reset so software can read them.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            port_wake_flag_r <= 1'b0;
            comparator_wake_flag_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (asleep && port_mismatch)
            begin
                port_wake_flag_r <= 1'b1;
            end
            else if (sleep_enter || awake_reset)
            begin
                port_wake_flag_r <= 1'b0;
            end
            if (asleep && cmp_mismatch)
            begin
                comparator_wake_flag_r <= 1'b1;
            end
            else if (sleep_enter || awake_reset)
            begin
                comparator_wake_flag_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Change-detect snapshots
    // ****************************************************************
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            port_snap_r <= '0;
            cmp_snap_r <= '0;
        end
        else if (CLK_EN)
        begin
            if (PORT_ACCESS_EXEC)
            begin
                port_snap_r <= PORT_PINS;
            end
            if (CMP_CONFIG_READ_EXEC)
            begin
                cmp_snap_r <= COMPARATOR_OUTPUTS;
            end
        end
    end

    AST_STALE_PORT: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && asleep && !port_wake_enable_n && port_mismatch
        |=> !asleep && port_wake_flag_r && DEVICE_RESET)
        else $error("port mismatch did not wake");

    AST_STALE_CMP: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && asleep && cmp_wake_en && cmp_mismatch
        |=> !asleep && comparator_wake_flag_r)
        else $error("comparator mismatch did not wake");

    // ****************************************************************
    // Watchdog counter and prescaler
    // ****************************************************************
    // The watchdog keeps counting in power-down; CLK stands in for its own oscillator.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wdt_cnt_r <= '0;
        end
        else if (CLK_EN)
        begin
            if (wdt_clear || !WDT_ENABLE)
            begin
                wdt_cnt_r <= '0;
            end
            else
            begin
                wdt_cnt_r <= wdt_cnt_r + 1'b1;
            end
        end
    end

    AST_WAKE_WDT_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && wake_any |=> wdt_cnt_r == '0 ##1 (wdt_cnt_r <= WDT_CNT_W'(1)))
        else $error("watchdog not cleared on wake");

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            psc_r <= '0;
        end
        else if (CLK_EN)
        begin
            if (psc_clear)
            begin
                psc_r <= '0;
            end
            else if (prescaler_assign ? wdt_base_tick : TIMER_SOURCE_TICK)
            begin
                psc_r <= psc_r + 1'b1;
            end
        end
    end

    AST_PSC_TMR_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && TIMER_WRITE_EXEC && !prescaler_assign |=> psc_r == '0)
        else $error("timer write did not clear prescaler");

    AST_PSC_WDT_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && WDT_CLEAR_EXEC && prescaler_assign |=> psc_r == '0 && wdt_cnt_r == '0)
        else $error("watchdog clear did not clear prescaler");

    AST_PSC_RESET: assert property (@(posedge CLK) disable iff (SYS_RST)
        DEVICE_RESET |-> psc_r == '0)
        else $error("prescaler not zero after reset");

    // Prescaled timer zero increment; undivided when the watchdog owns the prescaler.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            timer_inc_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (prescaler_assign)
            begin
                timer_inc_r <= TIMER_SOURCE_TICK && !any_reset;
            end
            else
            begin
                timer_inc_r <= TIMER_SOURCE_TICK && !psc_clear &&
                    ((psc_r & tmr_mask) == tmr_mask);
            end
        end
    end

    AST_TMR_RATIO: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLK_EN && !prescaler_assign && ((psc_r & tmr_mask) != tmr_mask) |=> !TIMER_INC)
        else $error("timer increment ahead of ratio");

    // ****************************************************************
    // Reset pulse
    // ****************************************************************
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            dev_reset_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            dev_reset_r <= any_reset;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Option reloads on every reset, a wake reset included.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            option_r <= OPTION_RESET;
            wake_ctrl_r <= WAKE_CTRL_RESET;
            irq_mask_r <= IRQ_RESET;
        end
        else if (CLK_EN)
        begin
            if (any_reset)
            begin
                option_r <= OPTION_RESET;
            end
            else if (WR && ADDR == OPTION_OFS)
            begin
                option_r <= WDATA;
            end
            if (WR && ADDR == WAKE_CTRL_OFS)
            begin
                wake_ctrl_r <= WDATA;
            end
            if (WR && ADDR == IRQ_MASK_OFS)
            begin
                irq_mask_r <= WDATA;
            end
        end
    end

    always_comb
    begin
        irq_events = '0;
        irq_events[IRQ_WAKE_BIT] = wake_any;
        irq_events[IRQ_WDT_BIT] = wdt_timeout;
        irq_events[IRQ_SLEEP_BIT] = sleep_enter;
        irq_clear = (WR && ADDR == IRQ_STAT_OFS) ? WDATA : '0;
        // A new event outranks a write-one clear in the same cycle.
        irq_stat_nxt = (irq_stat_r & ~irq_clear) | irq_events;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            irq_stat_r <= IRQ_RESET;
            irq_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    always_comb
    begin
        status_val = '0;
        status_val[ST_PORT_WAKE_BIT] = port_wake_flag_r;
        status_val[ST_CMP_WAKE_BIT] = comparator_wake_flag_r;
        status_val[ST_ASLEEP_BIT] = asleep;
        status_val[ST_TIMEOUT_N_BIT] = timeout_flag_n_r;
        status_val[ST_PWRDN_N_BIT] = powerdown_flag_n_r;
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rdata_r <= '0;
        end
        else if (CLK_EN)
        begin
            if (RD)
            begin
                unique case (ADDR)
                    OPTION_OFS: rdata_r <= option_r;
                    WAKE_CTRL_OFS: rdata_r <= wake_ctrl_r;
                    STATUS_OFS: rdata_r <= status_val;
                    IRQ_STAT_OFS: rdata_r <= irq_stat_r;
                    IRQ_MASK_OFS: rdata_r <= irq_mask_r;
                    default: rdata_r <= '0;
                endcase
            end
            else
            begin
                rdata_r <= '0;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign RDATA = rdata_r;
    assign TIMER_INC = timer_inc_r;
    assign DEVICE_RESET = dev_reset_r;
    // Both come from their own flops so that no decode glitch reaches the pads.
    assign OSC_DRIVER_EN = osc_en_r;
    assign PIN_HOLD = pin_hold_r;
    assign IRQ = irq_r;

endmodule

`default_nettype wire

/* tb/sleep_wake_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Pins, comparators and master clear seen from outside the device
// ****************************************************************
module sleep_wake_far_side
(
    input wire logic clk,
    output var logic master_clear_n,
    output var logic [sleep_wake_pkg::PORT_W-1:0] pins,
    output var logic [sleep_wake_pkg::CMP_W-1:0] cmp
);
    import sleep_wake_pkg::*;

    // The master clear line has a pull-up, so it idles high.
    initial
    begin
        master_clear_n = 1'b1;
        pins = '0;
        cmp = '0;
    end

    task automatic set_port(input logic [PORT_W-1:0] v);
        @(posedge clk);
        pins <= v;
    endtask

    task automatic set_cmp(input logic [CMP_W-1:0] v);
        @(posedge clk);
        cmp <= v;
    endtask

    task automatic pull_master_clear(input int len);
        @(posedge clk);
        master_clear_n <= 1'b0;
        repeat (len) @(posedge clk);
        master_clear_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* tb/sleep_wake_prescaler_test.sv */
`timescale 1ns/1ps
`default_nettype none

module sleep_wake_prescaler_test;
    import sleep_wake_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] instr = '0;
    logic wdt_en = 1'b0;
    logic clk_en = 1'b1;
    logic master_clear_en = 1'b1;
    logic [DATA_W-1:0] rdata;
    logic master_clear_n, timer_inc, dev_rst, osc_en, pin_hold, irq;
    logic [PORT_W-1:0] pins;
    logic [CMP_W-1:0] cmp;
    int fail_count = 0;
    int samples_checked = 0;
    int inc_cnt = 0;
    int rst_cnt = 0;
    int n0;

    always #25 clk = ~clk;

    sleep_wake_far_side u_sleep_wake_far_side (.clk(clk), .master_clear_n(master_clear_n),
        .pins(pins), .cmp(cmp));

    sleep_wake_prescaler #(.WDT_CYCLES(8)) u_sleep_wake_prescaler (
        .CLK(clk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SLEEP_EXEC(instr[0]), .WDT_CLEAR_EXEC(instr[1]),
        .TIMER_WRITE_EXEC(instr[2]), .PORT_ACCESS_EXEC(instr[3]),
        .CMP_CONFIG_READ_EXEC(instr[4]), .TIMER_SOURCE_TICK(instr[5]), .WDT_ENABLE(wdt_en),
        .MASTER_CLEAR_ENABLE(master_clear_en), .MASTER_CLEAR_PIN_N(master_clear_n),
        .PORT_PINS(pins), .COMPARATOR_OUTPUTS(cmp), .TIMER_INC(timer_inc), .DEVICE_RESET(dev_rst),
        .OSC_DRIVER_EN(osc_en), .PIN_HOLD(pin_hold), .IRQ(irq));

    // ****************************************************************
    // Event counters and helpers
    // ****************************************************************
    always @(posedge clk)
    begin
        if (timer_inc === 1'b1)
            inc_cnt <= inc_cnt + 1;
        if (dev_rst === 1'b1)
            rst_cnt <= rst_cnt + 1;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    // Instruction strobes: 0 sleep, 1 watchdog clear, 2 timer write, 3 port read,
    // 4 comparator config read, 5 timer source tick.
    task automatic pulse(input int i);
        @(posedge clk);
        instr[i] <= 1'b1;
        @(posedge clk);
        instr[i] <= 1'b0;
        #1;
    endtask

    task automatic wait_wake(input int lim);
        int r0;
        r0 = rst_cnt;
        for (int k = 0; k < lim && rst_cnt == r0; k++)
            @(posedge clk);
        #1;
        check(8'(rst_cnt - r0), 8'h01);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************************************
    // Watchdog on the whole run
    // ****************************************************************
    initial
    begin
        #500000;
        fail_count++;
        tally_and_finish();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wr_reg(3'h5, 8'hff);
        rd_chk(OPTION_OFS, 8'hff);
        rd_chk(STATUS_OFS, 8'h18);
        rd_chk(3'h5, 8'h00);
        $display("reset values done");
        // A stray tick before each timer write shows whether the write cleared it.
        for (int n = 0; n < 8; n++)
        begin
            wr_reg(OPTION_OFS, 8'hf0 | 8'(n));
            pulse(5);
            pulse(2);
            n0 = inc_cnt;
            repeat ((2 << n) - 1) pulse(5);
            @(posedge clk);
            #1;
            check(8'(inc_cnt - n0), 8'h00);
            pulse(5);
            repeat (2) @(posedge clk);
            #1;
            check(8'(inc_cnt - n0), 8'h01);
        end
        $display("timer prescaler done");
        @(posedge clk) wdt_en <= 1'b1;
        wr_reg(OPTION_OFS, 8'hf9);
        n0 = rst_cnt;
        repeat (6)
        begin
            repeat (8) @(posedge clk);
            pulse(1);
        end
        check(8'(rst_cnt - n0), 8'h00);
        wait_wake(40);
        rd_chk(STATUS_OFS, 8'h08);
        wr_reg(IRQ_MASK_OFS, 8'h02);
        @(posedge clk);
        #1;
        check(8'(irq), 8'h01);
        wr_reg(IRQ_STAT_OFS, 8'h02);
        @(posedge clk);
        #1;
        check(8'(irq), 8'h00);
        $display("watchdog awake done");
        wr_reg(OPTION_OFS, 8'hf8);
        pulse(0);
        check({6'h00, pin_hold, osc_en}, 8'h02);
        wait_wake(30);
        rd_chk(STATUS_OFS, 8'h00);
        check({6'h00, pin_hold, osc_en}, 8'h01);
        $display("watchdog wake done");
        @(posedge clk) wdt_en <= 1'b0;
        u_sleep_wake_far_side.set_port(4'h5);
        pulse(3);
        u_sleep_wake_far_side.set_port(4'ha);
        wr_reg(OPTION_OFS, 8'h7f);
        pulse(0);
        wait_wake(6);
        rd_chk(STATUS_OFS, 8'h90);
        $display("port wake done");
        wr_reg(WAKE_CTRL_OFS, 8'h01);
        u_sleep_wake_far_side.set_cmp(2'h0);
        // Re-read the port so that only the comparator can flag a wake.
        pulse(3);
        pulse(4);
        pulse(0);
        repeat (20) @(posedge clk);
        rd_chk(STATUS_OFS, 8'h30);
        u_sleep_wake_far_side.set_cmp(2'h2);
        wait_wake(8);
        rd_chk(STATUS_OFS, 8'h50);
        $display("comparator wake done");
        pulse(4);
        pulse(0);
        // One low cycle: a pin still low after the wake would reset again while awake.
        u_sleep_wake_far_side.pull_master_clear(1);
        wait_wake(10);
        rd_chk(STATUS_OFS, 8'h10);
        $display("master clear wake done");
        n0 = inc_cnt;
        pulse(5);
        @(posedge clk);
        #1;
        check(8'(inc_cnt - n0), 8'h01);
        wr_reg(OPTION_OFS, 8'hf0);
        pulse(2);
        @(posedge clk) clk_en <= 1'b0;
        n0 = inc_cnt;
        repeat (4) pulse(5);
        @(posedge clk) clk_en <= 1'b1;
        check(8'(inc_cnt - n0), 8'h00);
        repeat (2) pulse(5);
        repeat (2) @(posedge clk);
        #1;
        check(8'(inc_cnt - n0), 8'h01);
        $display("clock enable done");
        @(posedge clk) master_clear_en <= 1'b0;
        n0 = rst_cnt;
        u_sleep_wake_far_side.pull_master_clear(1);
        repeat (3) @(posedge clk);
        #1;
        check(8'(rst_cnt - n0), 8'h00);
        rd_chk(IRQ_STAT_OFS, 8'h07);
        $display("master clear disable done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
